// ---- design/vfp_core.sv ----
`timescale 1ns/1ns
// Summary of operation
// - Mono, 4:2:2, 4:4:4 or RGB selectable
// - Three planes serial interleaved, parallel packed
// - Serial 4:2:2 order Cb Y Cr Y
// - Parallel 4:2:2: luma high, chroma alternating low
// - Output gate acts within 16 clocks
// - No conversion: output after complete input frame
// - No conversion: new input abandons output frame
// - No conversion: stop after last input frame
// - Conversion: output paced by clock and gate
// - Conversion: drop oldest, show next oldest
// - Conversion: repeat newest frame when idle
// - Storage full: overwrite newest input frame
// - Write bursts from half full until empty
// - Read when below half, no writing
// - Bursts only, switch at burst boundary
// - Parameter bus on pixel clock
// - Parameter writes only while commit clear
// - Commit loads at frame start, self-clears
// - Width and height 64 to 4096
// - Burst length 2, 4 or 8
// - Output frame start with first pixel
// - Unwritten parameters keep prior value
// - Never write and read command together
module vfp_core import vfp_pkg::*; #(
	parameter int PIX_W = 8,
	parameter int MEM_W = 32,
	parameter int WFIFO_DEPTH = 64,
	parameter int RFIFO_DEPTH = 64,
	parameter int BURST = 8,
	parameter int NFRM = 4,
	parameter logic [31:0] MEM_BASE = 32'h0000_0000,
	parameter logic [31:0] FRAME_STRIDE = 32'h0100_0000
) (
	input wire logic pclk, // Clock for all logic
	input wire logic presetn, // Async reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [3*PIX_W-1:0] din, // Input samples
	input wire logic dvalid_in, // Input sample valid
	input wire logic frmsync_in, // First sample of frame
	output logic ready_out, // Core accepts input
	output logic [3*PIX_W-1:0] dout, // Output samples
	output logic dvalid_out, // Output sample valid
	output logic frmsync_out, // First sample of output frame
	input wire logic dout_enable, // Output gate from sink
	input wire logic cmd_ready, // Controller takes command
	output logic [31:0] mem_addr, // Burst byte address
	output logic read_cmd, // Read burst command
	input wire logic [MEM_W-1:0] read_data, // Read beat
	input wire logic read_data_valid, // Read beat valid
	output logic write_cmd, // Write burst command
	output logic [MEM_W-1:0] write_data, // Write beat
	input wire logic write_data_ready // Controller wants a beat
);
	localparam int DW = 3 * PIX_W;
	localparam int SW = (NFRM > 1) ? $clog2(NFRM) : 1;
	localparam int WCW = $clog2(WFIFO_DEPTH) + 1;
	localparam int RCW = $clog2(RFIFO_DEPTH) + 1;
	localparam logic [WCW-1:0] WHALF = WCW'(WFIFO_DEPTH / 2);
	localparam logic [WCW-1:0] WSTOP = WCW'(WFIFO_DEPTH - 3);
	localparam logic [RCW-1:0] RHALF = RCW'(RFIFO_DEPTH / 2);
	localparam logic [3:0] BLAST = 4'(BURST - 1);
	localparam logic [LEN_W-1:0] BLEN = LEN_W'(BURST);
	localparam logic [31:0] BPB = 32'(MEM_W / 8);
	localparam logic [SW:0] STMAX = (SW+1)'(NFRM - 1);

	if (BURST != 2 && BURST != 4 && BURST != 8) begin : g_bad_burst
		$error("Burst length must be 2, 4 or 8");
	end
	if (NFRM < 2 || (1 << SW) != NFRM) begin : g_bad_nfrm
		$error("Frame slot count must be a power of two, at least 2");
	end
	if (MEM_W < DW || MEM_W % 8 != 0) begin : g_bad_memw
		$error("Memory width must hold one sample word");
	end
	if (WFIFO_DEPTH / 2 < BURST || RFIFO_DEPTH / 2 < BURST) begin : g_bad_fifo
		$error("FIFO half must hold a full burst");
	end
	if (GATE_STAGES + 1 >= GATE_DELAY_MAX) begin : g_bad_gate
		$error("Output gate latency too long");
	end

	function automatic logic [DIM_W-1:0] clamp_dim(input logic [31:0] v);
		if (v < 32'(DIM_MIN)) begin
			return DIM_MIN;
		end else if (v > 32'(DIM_MAX)) begin
			return DIM_MAX;
		end
		return v[DIM_W-1:0];
	endfunction

	function automatic logic reg_mapped(input logic [7:0] a);
		return a == OFS_CTRL || a == OFS_WIDTH || a == OFS_HEIGHT ||
			a == OFS_FIELD || a == OFS_STATUS || a == OFS_ACTIVE;
	endfunction

	function automatic logic [SW-1:0] slot_next(input logic [SW-1:0] s);
		return s + SW'(1);
	endfunction

	vfp_cfg_t sh_q;
	vfp_cfg_t wk_q;
	logic commit_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [LEN_W-1:0] frm_len_q;
	logic in_act_q;
	logic tail_q;
	logic ready_q;
	logic [LEN_W-1:0] in_cnt_q;
	logic wr_run_q;
	vfp_mstate_t ms_q;
	logic [3:0] bcnt_q;
	logic [1:0] dcnt_q;
	logic [LEN_W-1:0] wr_beat_q;
	logic [LEN_W-1:0] rd_beat_q;
	logic [LEN_W-1:0] rx_beat_q;
	logic drop_q;
	logic [SW-1:0] wr_slot_q;
	logic [SW-1:0] out_slot_q;
	logic [SW:0] st_cnt_q;
	logic out_act_q;
	logic [LEN_W-1:0] out_cnt_q;
	logic [GATE_STAGES-1:0] gate_q;
	logic [DW-1:0] wpipe_q;
	logic [MEM_W-1:0] wdata_q;
	logic [31:0] mem_addr_q;
	logic wcmd_q;
	logic rcmd_q;
	logic [DW-1:0] dout_q;
	logic dvalid_q;
	logic fsync_q;

	logic wr_en;
	logic rd_ph;
	logic acc;
	logic frm_start;
	logic last_in;
	logic frm_done;
	logic abandon;
	logic out_end;
	logic frc_start;
	logic pop_o;
	logic wpop;
	logic wr_go;
	logic rd_go;
	logic rpush;
	logic [31:0] waddr;
	logic [31:0] raddr;
	logic [DW-1:0] w_rdata;
	logic [DW-1:0] r_rdata;
	logic [WCW-1:0] w_cnt;
	logic [RCW-1:0] r_cnt;
	logic w_empty;
	logic r_empty;

	// Registers are reached on the same clock as the pixel input
	assign wr_en = psel & penable & pready_q & pwrite;
	assign rd_ph = psel & penable & ~pready_q;
	assign acc = dvalid_in & ready_q;
	assign frm_start = acc & frmsync_in;
	assign last_in = acc & (in_act_q | frmsync_in) &
		(frmsync_in ? frm_len_q == LEN_W'(1) : in_cnt_q == frm_len_q - 1'b1);
	assign frm_done = tail_q & w_empty & ms_q == MS_IDLE & ~wr_run_q;
	assign abandon = frm_done & ~wk_q.frc;
	assign frc_start = wk_q.frc & ~out_act_q & st_cnt_q != '0;
	assign pop_o = gate_q[GATE_STAGES-1] & out_act_q & ~r_empty;
	assign out_end = pop_o & out_cnt_q == frm_len_q - 1'b1;
	assign wpop = ms_q == MS_WDATA & write_data_ready;
	assign wr_go = wr_run_q | (tail_q & ~w_empty);
	assign rd_go = out_act_q & ~wr_go & r_cnt < RHALF &
		rd_beat_q < frm_len_q & ~abandon & ~out_end;
	assign rpush = ms_q == MS_RWAIT & read_data_valid & ~drop_q &
		rx_beat_q < frm_len_q;
	assign waddr = MEM_BASE + 32'(wr_slot_q) * FRAME_STRIDE +
		32'(wr_beat_q) * BPB;
	assign raddr = MEM_BASE + 32'(out_slot_q) * FRAME_STRIDE +
		32'(rd_beat_q) * BPB;

	vfp_fifo #(.W(DW), .DEPTH(WFIFO_DEPTH)) u_wfifo (
		.clk(pclk),
		.rst_n(presetn),
		.flush(1'b0),
		.push(acc & (in_act_q | frmsync_in)),
		.wdata(din),
		.pop(wpop),
		.rdata(w_rdata),
		.count(w_cnt),
		.full(),
		.empty(w_empty)
	);

	vfp_fifo #(.W(DW), .DEPTH(RFIFO_DEPTH)) u_rfifo (
		.clk(pclk),
		.rst_n(presetn),
		.flush(abandon | out_end),
		.push(rpush),
		.wdata(read_data[DW-1:0]),
		.pop(pop_o),
		.rdata(r_rdata),
		.count(r_cnt),
		.full(),
		.empty(r_empty)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= rd_ph;
			pslverr_q <= rd_ph & ~reg_mapped(paddr);
			if (rd_ph) begin
				prdata_q <= 32'h0000_0000;
				case (paddr)
				OFS_CTRL: begin
					prdata_q[CTRL_COMMIT_BIT] <= commit_q;
					prdata_q[CTRL_FRC_BIT] <= sh_q.frc;
					prdata_q[CTRL_PAR_BIT] <= sh_q.par;
					prdata_q[CTRL_FMT_LSB +: 2] <= sh_q.fmt;
				end
				OFS_WIDTH: prdata_q[DIM_W-1:0] <= sh_q.width;
				OFS_HEIGHT: prdata_q[DIM_W-1:0] <= sh_q.height;
				OFS_FIELD: prdata_q[0] <= sh_q.field;
				OFS_STATUS: prdata_q[15:0] <= 16'({st_cnt_q, wr_slot_q,
					out_slot_q, out_act_q, in_act_q, tail_q, ms_q});
				OFS_ACTIVE: begin
					prdata_q[DIM_W-1:0] <= wk_q.width;
					prdata_q[ACTIVE_HEIGHT_LSB +: DIM_W] <= wk_q.height;
				end
				default: prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Shadow set keeps every unwritten field across a commit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_q <= '{RST_FMT, RST_PAR, RST_FRC, RST_FIELD, RST_WIDTH,
				RST_HEIGHT};
			wk_q <= '{RST_FMT, RST_PAR, RST_FRC, RST_FIELD, RST_WIDTH,
				RST_HEIGHT};
			commit_q <= 1'b0;
		end else begin
			if (frm_start && commit_q) begin
				wk_q <= sh_q;
				commit_q <= 1'b0;
			end
			if (wr_en && !commit_q) begin
				case (paddr)
				OFS_CTRL: begin
					commit_q <= pwdata[CTRL_COMMIT_BIT];
					sh_q.frc <= pwdata[CTRL_FRC_BIT];
					sh_q.par <= pwdata[CTRL_PAR_BIT];
					sh_q.fmt <= vfp_fmt_t'(pwdata[CTRL_FMT_LSB +: 2]);
				end
				OFS_WIDTH: sh_q.width <= clamp_dim(pwdata);
				OFS_HEIGHT: sh_q.height <= clamp_dim(pwdata);
				OFS_FIELD: sh_q.field <= pwdata[0];
				default: sh_q <= sh_q;
				endcase
			end
		end
	end

	// Serial three-plane uses three words per pixel, serial 4:2:2 two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frm_len_q <= LEN_W'(RST_WIDTH) * LEN_W'(RST_HEIGHT);
		end else begin
			frm_len_q <= LEN_W'(wk_q.width) * LEN_W'(wk_q.height) *
				LEN_W'(vfp_spp(wk_q));
		end
	end

	// Input held off while a finished frame drains to memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_act_q <= 1'b0;
			in_cnt_q <= '0;
			tail_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			if (last_in) begin
				in_act_q <= 1'b0;
				in_cnt_q <= '0;
			end else if (frm_start) begin
				in_act_q <= 1'b1;
				in_cnt_q <= LEN_W'(1);
			end else if (acc && in_act_q) begin
				in_cnt_q <= in_cnt_q + 1'b1;
			end
			if (last_in) begin
				tail_q <= 1'b1;
			end else if (frm_done) begin
				tail_q <= 1'b0;
			end
			ready_q <= ~last_in & ~(tail_q & ~frm_done) & w_cnt < WSTOP;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_run_q <= 1'b0;
		end else if (w_cnt >= WHALF) begin
			wr_run_q <= 1'b1;
		end else if (ms_q == MS_WDRAIN && dcnt_q == 2'(WDATA_DELAY - 1) &&
			w_empty) begin
			wr_run_q <= 1'b0;
		end
	end

	// One state machine owns both commands, so they never overlap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_q <= MS_IDLE;
			wcmd_q <= 1'b0;
			rcmd_q <= 1'b0;
			mem_addr_q <= 32'h0000_0000;
			bcnt_q <= 4'h0;
			dcnt_q <= 2'h0;
		end else begin
			case (ms_q)
			MS_IDLE: begin
				if (wr_go) begin
					ms_q <= MS_WCMD;
					wcmd_q <= 1'b1;
					mem_addr_q <= waddr;
				end else if (rd_go) begin
					ms_q <= MS_RCMD;
					rcmd_q <= 1'b1;
					mem_addr_q <= raddr;
				end
			end
			MS_WCMD: begin
				if (cmd_ready) begin
					wcmd_q <= 1'b0;
					bcnt_q <= 4'h0;
					ms_q <= MS_WDATA;
				end
			end
			MS_WDATA: begin
				if (write_data_ready) begin
					bcnt_q <= bcnt_q + 4'h1;
					if (bcnt_q == BLAST) begin
						dcnt_q <= 2'h0;
						ms_q <= MS_WDRAIN;
					end
				end
			end
			MS_WDRAIN: begin
				dcnt_q <= dcnt_q + 2'h1;
				if (dcnt_q == 2'(WDATA_DELAY - 1)) begin
					ms_q <= MS_IDLE;
				end
			end
			MS_RCMD: begin
				if (cmd_ready) begin
					rcmd_q <= 1'b0;
					bcnt_q <= 4'h0;
					ms_q <= MS_RWAIT;
				end
			end
			MS_RWAIT: begin
				if (read_data_valid) begin
					bcnt_q <= bcnt_q + 4'h1;
					if (bcnt_q == BLAST) begin
						ms_q <= MS_IDLE;
					end
				end
			end
			default: ms_q <= MS_IDLE;
			endcase
		end
	end

	// Beat lands two clocks after its ready; an empty FIFO pads zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wpipe_q <= '0;
			wdata_q <= '0;
		end else begin
			wpipe_q <= (wpop && !w_empty) ? w_rdata : '0;
			wdata_q <= MEM_W'(wpipe_q);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_beat_q <= '0;
		end else if (frm_done) begin
			wr_beat_q <= '0;
		end else if (ms_q == MS_WCMD && cmd_ready) begin
			wr_beat_q <= wr_beat_q + BLEN;
		end
	end

	// Beats of a burst issued before an abandon are thrown away
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_beat_q <= '0;
			rx_beat_q <= '0;
			drop_q <= 1'b0;
		end else begin
			if (abandon || out_end) begin
				rd_beat_q <= '0;
				rx_beat_q <= '0;
				drop_q <= ms_q == MS_RCMD || ms_q == MS_RWAIT;
			end else begin
				if (ms_q == MS_RCMD && cmd_ready && !drop_q) begin
					rd_beat_q <= rd_beat_q + BLEN;
				end
				if (rpush) begin
					rx_beat_q <= rx_beat_q + 1'b1;
				end
				if (ms_q == MS_RWAIT && read_data_valid && bcnt_q == BLAST) begin
					drop_q <= 1'b0;
				end
			end
		end
	end

	// Frame slots: a full store keeps rewriting the newest slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_slot_q <= '0;
			st_cnt_q <= '0;
		end else begin
			if (frm_done && (!wk_q.frc || st_cnt_q < STMAX)) begin
				wr_slot_q <= slot_next(wr_slot_q);
			end
			st_cnt_q <= st_cnt_q +
				(SW+1)'(frm_done & wk_q.frc & (st_cnt_q < STMAX)) -
				(SW+1)'(out_end & wk_q.frc & (st_cnt_q > (SW+1)'(1)));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_act_q <= 1'b0;
			out_slot_q <= '0;
			out_cnt_q <= '0;
		end else if (abandon) begin
			out_act_q <= 1'b1;
			out_slot_q <= wr_slot_q;
			out_cnt_q <= '0;
		end else if (out_end) begin
			out_act_q <= 1'b0;
			out_cnt_q <= '0;
			if (wk_q.frc && st_cnt_q > (SW+1)'(1)) begin
				out_slot_q <= slot_next(out_slot_q);
			end
		end else if (frc_start) begin
			out_act_q <= 1'b1;
		end else if (pop_o) begin
			out_cnt_q <= out_cnt_q + 1'b1;
		end
	end

	// Gate sampled through a short pipe to keep the pop path registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_q <= '0;
			dout_q <= '0;
			dvalid_q <= 1'b0;
			fsync_q <= 1'b0;
		end else begin
			gate_q <= {gate_q[GATE_STAGES-2:0], dout_enable};
			dvalid_q <= pop_o;
			fsync_q <= pop_o & out_cnt_q == '0;
			if (pop_o) begin
				dout_q <= r_rdata;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign ready_out = ready_q;
	assign dout = dout_q;
	assign dvalid_out = dvalid_q;
	assign frmsync_out = fsync_q;
	assign mem_addr = mem_addr_q;
	assign read_cmd = rcmd_q;
	assign write_cmd = wcmd_q;
	assign write_data = wdata_q;
endmodule

// ---- shared/vfp_pkg.sv ----
package vfp_pkg;

	typedef enum logic [1:0] {
		FMT_MONO = 2'b00,
		FMT_Y422 = 2'b01,
		FMT_Y444 = 2'b10,
		FMT_RGB = 2'b11
	} vfp_fmt_t;

	typedef enum logic [2:0] {
		MS_IDLE = 3'b000,
		MS_WCMD = 3'b001,
		MS_WDATA = 3'b010,
		MS_WDRAIN = 3'b011,
		MS_RCMD = 3'b100,
		MS_RWAIT = 3'b101
	} vfp_mstate_t;

	localparam int DIM_W = 13;
	localparam int LEN_W = 26;

	typedef struct packed {
		vfp_fmt_t fmt;
		logic par;
		logic frc;
		logic field;
		logic [DIM_W-1:0] width;
		logic [DIM_W-1:0] height;
	} vfp_cfg_t;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_WIDTH = 8'h04;
	localparam logic [7:0] OFS_HEIGHT = 8'h08;
	localparam logic [7:0] OFS_FIELD = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_ACTIVE = 8'h14;

	// Control and active register fields
	localparam int CTRL_COMMIT_BIT = 0;
	localparam int CTRL_FRC_BIT = 1;
	localparam int CTRL_PAR_BIT = 2;
	localparam int CTRL_FMT_LSB = 4;
	localparam int ACTIVE_HEIGHT_LSB = 16;

	// Reset values
	localparam logic [DIM_W-1:0] RST_WIDTH = 13'h02D0;
	localparam logic [DIM_W-1:0] RST_HEIGHT = 13'h01E0;
	localparam vfp_fmt_t RST_FMT = FMT_Y422;
	localparam logic RST_PAR = 1'b1;
	localparam logic RST_FRC = 1'b1;
	localparam logic RST_FIELD = 1'b0;

	localparam logic [DIM_W-1:0] DIM_MIN = 13'h0040;
	localparam logic [DIM_W-1:0] DIM_MAX = 13'h1000;

	// Timing counts, in clocks
	localparam int WDATA_DELAY = 2;
	localparam int GATE_STAGES = 2;
	localparam int GATE_DELAY_MAX = 16;

	function automatic logic [1:0] vfp_spp(input vfp_cfg_t c);
		if (c.par || c.fmt == FMT_MONO) begin
			return 2'h1;
		end else if (c.fmt == FMT_Y422) begin
			return 2'h2;
		end
		return 2'h3;
	endfunction

endpackage

// ---- design/vfp_fifo.sv ----
`timescale 1ns/1ns
module vfp_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 64
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Async reset, low
	input wire logic flush, // Drop all contents
	input wire logic push, // Write strobe
	input wire logic [W-1:0] wdata, // Write data
	input wire logic pop, // Read strobe
	output logic [W-1:0] rdata, // Head word
	output logic [$clog2(DEPTH):0] count, // Words held
	output logic full, // No room
	output logic empty // Nothing held
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("FIFO depth must be a power of two, at least 4");
	end

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push_ok;
	logic pop_ok;

	assign full = cnt_q[AW];
	assign empty = cnt_q == '0;
	assign count = cnt_q;
	assign rdata = mem[rp_q];
	assign push_ok = push & ~full;
	assign pop_ok = pop & ~empty;

	always_ff @(posedge clk) begin
		if (push_ok) begin
			mem[wp_q] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_q + AW'(push_ok);
			rp_q <= rp_q + AW'(pop_ok);
			cnt_q <= cnt_q + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
		end
	end
endmodule

// ---- dv/vfp_core_asserts.sv ----
`timescale 1ns/1ns
module vfp_core_asserts import vfp_pkg::*; (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic dvalid_out, // Output valid
	input wire logic frmsync_out, // Output frame start
	input wire logic dout_enable, // Output gate
	input wire logic cmd_ready, // Command taken
	input wire logic [31:0] mem_addr, // Burst address
	input wire logic read_cmd, // Read command
	input wire logic write_cmd // Write command
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_CMD_EXCL: assert property (!(write_cmd && read_cmd))
		else $error("write and read command together");
	AST_WCMD_HOLD: assert property (write_cmd && !cmd_ready
		|=> write_cmd && $stable(mem_addr))
		else $error("write command dropped before taken");
	AST_RCMD_HOLD: assert property (read_cmd && !cmd_ready
		|=> read_cmd && $stable(mem_addr))
		else $error("read command dropped before taken");
	AST_WCMD_DROP: assert property (write_cmd && cmd_ready
		|=> !write_cmd)
		else $error("write command held after taken");
	// A burst of eight beats needs at least eight cycles
	AST_WR_NO_RD: assert property (write_cmd && cmd_ready
		|=> !read_cmd [*8])
		else $error("read command inside write burst");
	AST_GATE_OFF: assert property (!dout_enable [*8]
		|=> !dvalid_out)
		else $error("output kept flowing with gate low");
	AST_FSYNC: assert property (frmsync_out |-> dvalid_out)
		else $error("frame start without valid sample");
	AST_PREADY_WAIT: assert property (psel && $rose(penable)
		|-> !pready ##1 pready)
		else $error("ready not after one wait state");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_SLVERR: assert property (pslverr |-> pready)
		else $error("error without ready");

	cover property (write_cmd && cmd_ready);
	cover property (read_cmd && cmd_ready);
	cover property (frmsync_out);
	cover property (pslverr);
endmodule

// ---- dv/vfp_mem_model.sv ----
`timescale 1ns/1ns
module vfp_mem_model import vfp_pkg::*; #(
	parameter int MEM_W = 32,
	parameter int BURST = 8
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, low
	input wire logic slow, // Stall every other cycle
	input wire logic write_cmd, // Write command
	input wire logic read_cmd, // Read command
	input wire logic [31:0] mem_addr, // Burst address
	input wire logic [MEM_W-1:0] write_data, // Write beat
	output logic cmd_ready, // Command taken
	output logic write_data_ready, // Beat wanted
	output logic [MEM_W-1:0] read_data, // Read beat
	output logic read_data_valid // Read beat valid
);
	logic [MEM_W-1:0] mem [int];
	logic [31:0] base, a, wa1, wa2, wa3;
	logic wr, v1, v2, v3, skip;
	int beats, gap;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ready <= 1'b0;
			write_data_ready <= 1'b0;
			read_data_valid <= 1'b0;
			read_data <= '0;
			{v1, v2, v3, skip} <= 4'h0;
			beats <= 0;
			gap <= 0;
		end else begin
			cmd_ready <= 1'b0;
			write_data_ready <= 1'b0;
			read_data_valid <= 1'b0;
			// Idle bus never repeats the last beat
			read_data <= ~read_data;
			{v2, v3, wa2, wa3} <= {v1, v2, wa1, wa2};
			v1 <= 1'b0;
			skip <= slow && !skip;
			// Beat lands two cycles after its ready pulse
			if (v3) begin
				mem[wa3] = write_data;
			end
			if (gap > 0) begin
				gap <= gap - 1;
			end
			if (beats == 0 && gap == 0 && !cmd_ready &&
				(write_cmd || read_cmd)) begin
				cmd_ready <= 1'b1;
				base <= mem_addr;
				wr <= write_cmd;
				beats <= BURST;
			end else if (beats > 0 && !cmd_ready && !skip) begin
				a = base + 32'((BURST - beats) * (MEM_W / 8));
				if (wr) begin
					write_data_ready <= 1'b1;
					v1 <= 1'b1;
					wa1 <= a;
				end else begin
					read_data_valid <= 1'b1;
					read_data <= mem.exists(a) ? mem[a] : '1;
				end
				beats <= beats - 1;
				if (beats == 1) begin
					gap <= 2;
				end
			end
		end
	end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
module tb_top import vfp_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, mem_addr, read_data, write_data, rd;
	logic [23:0] din, dout, first_pix;
	logic dvalid_in, frmsync_in, ready_out, dvalid_out, frmsync_out;
	logic dout_enable, cmd_ready, read_cmd, write_cmd, er, slow;
	logic read_data_valid, write_data_ready;
	int err_count, tests_run, out_cnt, fs_cnt, c;

	vfp_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .din, .dvalid_in,
		.frmsync_in, .ready_out, .dout, .dvalid_out, .frmsync_out,
		.dout_enable, .cmd_ready, .mem_addr, .read_cmd, .read_data,
		.read_data_valid, .write_cmd, .write_data, .write_data_ready);
	vfp_mem_model mem (.clk(pclk), .rst_n(presetn), .slow, .write_cmd,
		.read_cmd, .mem_addr, .write_data, .cmd_ready, .write_data_ready,
		.read_data, .read_data_valid);

	always #5 pclk = ~pclk;

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Answer taken at the edge that ends the access, then released
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		chk("apb answer", 1, n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task send(input logic [23:0] b);
		int i, g;
		logic acc;
		i = 0;
		g = 0;
		frmsync_in <= 1'b1;
		din <= b;
		dvalid_in <= 1'b1;
		while (i < 4096 && g < 30000) begin
			@(negedge pclk);
			acc = ready_out;
			@(posedge pclk);
			g++;
			if (acc === 1'b1) begin
				i++;
				frmsync_in <= 1'b0;
				din <= b + 24'(i);
			end
		end
		dvalid_in <= 1'b0;
		chk("samples in", 4096, i);
	endtask

	task wait_out(input int n, input int f);
		int g;
		g = 0;
		while ((out_cnt < n || fs_cnt < f) && g < 30000) begin
			cyc(1);
			g++;
		end
		chk("output wait", 1, g < 30000);
	endtask

	always @(negedge pclk) begin
		if (dvalid_out === 1'b1) begin
			if (frmsync_out === 1'b1) begin
				fs_cnt++;
				first_pix = dout;
				out_cnt = 0;
			end
			chk("pixel", 32'(first_pix + 24'(out_cnt)), 32'(dout));
			out_cnt++;
		end
	end

	task t_regs;
		apb(0, OFS_CTRL, 0);
		chk("ctrl reset", 32'h16, rd);
		apb(0, OFS_WIDTH, 0);
		chk("width reset", 32'(RST_WIDTH), rd);
		apb(0, 8'h18, 0);
		chk("unmapped err", 1, er);
		chk("unmapped data", 0, rd);
		apb(1, OFS_WIDTH, 32'h10);
		apb(0, OFS_WIDTH, 0);
		chk("width low clamp", 32'(DIM_MIN), rd);
		apb(1, OFS_HEIGHT, 32'h2000);
		apb(0, OFS_HEIGHT, 0);
		chk("height high clamp", 32'(DIM_MAX), rd);
		apb(1, OFS_WIDTH, 64);
		apb(1, OFS_HEIGHT, 64);
	endtask

	task t_commit;
		apb(1, OFS_CTRL, 32'h15);
		apb(0, OFS_CTRL, 0);
		chk("commit pending", 32'h15, rd);
		apb(1, OFS_WIDTH, 100);
		apb(0, OFS_WIDTH, 0);
		chk("write while pending", 64, rd);
		apb(0, OFS_ACTIVE, 0);
		chk("working before", 32'h01E0_02D0, rd);
		send(24'h0);
		chk("output before frame", 0, out_cnt);
		apb(0, OFS_CTRL, 0);
		chk("commit cleared", 32'h14, rd);
		apb(0, OFS_ACTIVE, 0);
		chk("working after", 32'h0040_0040, rd);
	endtask

	task t_gate;
		wait_out(100, 1);
		chk("first pixel", 0, 32'(first_pix));
		dout_enable <= 1'b0;
		cyc(20);
		c = out_cnt;
		cyc(40);
		chk("gate stop", 32'(c), 32'(out_cnt));
		dout_enable <= 1'b1;
		cyc(16);
		chk("gate resume", 1, out_cnt > c);
	endtask

	task t_abandon;
		wait_out(500, 1);
		dout_enable <= 1'b0;
		slow <= 1'b1;
		send(24'h1000);
		dout_enable <= 1'b1;
		wait_out(4096, 2);
		chk("output frames", 2, fs_cnt);
		chk("new frame first", 32'h1000, 32'(first_pix));
		chk("frame length", 4096, out_cnt);
		cyc(300);
		chk("after last frame", 4096, out_cnt);
		chk("no more starts", 2, fs_cnt);
	endtask

	// Fresh reset so the stored frames start empty in conversion mode
	task t_frc;
		presetn <= 1'b0;
		slow <= 1'b0;
		cyc(4);
		presetn <= 1'b1;
		cyc(1);
		out_cnt = 0;
		fs_cnt = 0;
		apb(1, OFS_WIDTH, 64);
		apb(1, OFS_HEIGHT, 64);
		apb(1, OFS_CTRL, 32'h17);
		send(24'h2000);
		wait_out(4096, 2);
		chk("frc frames", 2, fs_cnt);
		chk("frc repeat", 32'h2000, 32'(first_pix));
		chk("frc length", 4096, out_cnt);
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#900000;
		err_count++;
		wrap_up;
	end

	initial begin
		{pclk, presetn, psel, penable, pwrite, slow} = 6'h00;
		{paddr, pwdata, din} = '0;
		{dvalid_in, frmsync_in, dout_enable} = 3'h1;
		{err_count, tests_run, out_cnt, fs_cnt} = 128'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_commit;
		t_gate;
		t_abandon;
		t_frc;
		wrap_up;
	end
endmodule

bind vfp_core vfp_core_asserts u_chk (.pclk, .presetn, .psel, .penable,
	.pready, .pslverr, .dvalid_out, .frmsync_out, .dout_enable,
	.cmd_ready, .mem_addr, .read_cmd, .write_cmd);
